//--- shared/pwi_pkg.sv
// Shared constants and types for the per-port wake and interrupt register bank.
`default_nettype none
package pwi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: word address = {port nibble, register index}.
  localparam logic [3:0]  PWI_PORT_MIN     = 4'h1;
  localparam logic [3:0]  PWI_PORT_MAX     = 4'h6;
  localparam int          PWI_PORT_FIRST   = 1;
  localparam int          PWI_PORT_LAST    = 6;
  localparam int          PWI_PHY_LAST     = 5;
  localparam int          PWI_PORT_MSB     = 15;
  localparam int          PWI_PORT_LSB     = 12;
  localparam logic [11:0] PWI_REG_TAG_HIGH = 12'h000;
  localparam logic [11:0] PWI_REG_TAG_LOW  = 12'h001;
  localparam logic [11:0] PWI_REG_EVT      = 12'h013;
  localparam logic [11:0] PWI_REG_ENA      = 12'h017;
  localparam logic [11:0] PWI_REG_IRQ      = 12'h01b;
  localparam logic [11:0] PWI_REG_MASK     = 12'h01f;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int PWI_BIT_MAGIC  = 2;
  localparam int PWI_BIT_LINK   = 1;
  localparam int PWI_BIT_ENERGY = 0;
  localparam int PWI_BIT_PHY    = 1;
  localparam int PWI_BIT_ACL    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [7:0] PWI_TAG_HIGH_RST = 8'h00;
  localparam logic [7:0] PWI_TAG_LOW_RST  = 8'h01;
  localparam logic [2:0] PWI_EVT_RST      = 3'h0;
  localparam logic [2:0] PWI_ENA_RST      = 3'h0;
  localparam logic [1:0] PWI_MASK_RST     = 2'h0;
  localparam logic [7:0] PWI_RDATA_RST    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    PWI_BUS_IDLE = 2'b00,
    PWI_BUS_DONE = 2'b01
  } pwi_bus_e;

  typedef struct packed {
    logic [7:0] tag_high;
    logic [7:0] tag_low;
    logic [2:0] evt;
    logic [2:0] ena;
    logic       acl_st;
    logic [1:0] mask;
  } pwi_port_s;

  typedef struct packed {
    pwi_port_s [6:1] port;
    pwi_bus_e        bus;
    logic [7:0]      rdata;
  } pwi_state_s;

  // One-cycle event pulses and levels from the switch core, one bit per port.
  typedef struct packed {
    logic [6:1] magic;
    logic [6:1] link;
    logic [6:1] energy;
    logic [6:1] phy_irq;
    logic [6:1] acl_irq;
  } pwi_evt_s;

endpackage
`default_nettype wire

//--- rtl/pwi_port_regs.sv
// Per-port default tag, wake event and interrupt register bank on Avalon-MM.
`default_nettype none
`timescale 1ns/100ps

// Contract
// - Decode port nibble; ports 1-6, PHY 1-5.
// - Tag high byte RW, resets zero.
// - Tag low byte RW, resets one.
// - Magic packet sets event bit 2.
// - Link up sets bit 1, PHY ports.
// - Cable energy sets bit 0, PHY ports.
// - Enable bit 2 lets magic drive wake.
// - Enable bit 1 lets link drive wake.
// - Enable bit 0 lets energy drive wake.
// - Status bit 1 shows PHY irq, PHY only.
// - Status bit 0 set by ACL counter irq.
// - ACL status cleared by mask bit toggle.
// - Interrupt gated by per-port mask register; status reads ungated.
// - Mask bit1 PHY, bit0 ACL, 0 enables.
module pwi_port_regs
  import pwi_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [15:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [7:0] avs_writedata,
  output logic      [7:0] avs_readdata,
  output logic            avs_waitrequest,
  input  wire pwi_evt_s   port_evt,
  output logic            wake_output,
  output logic            port_irq
);

  pwi_state_s  st;
  pwi_state_s  next_st;
  logic [3:0]  sel_port;
  logic [11:0] sel_reg;
  logic        addr_hit;
  logic [6:1]  is_phy;
  logic [6:1]  wake_hit;
  logic [6:1]  irq_hit;
  logic [6:1]  ena_set;
  logic [1:0]  flags [6:1];

  ////////////////////////////////////////////////////////////////////////////
  // Address split; only port nibbles 1 to 6 reach a register.
  assign sel_port = avs_address[PWI_PORT_MSB:PWI_PORT_LSB];
  assign sel_reg  = avs_address[PWI_PORT_LSB-1:0];
  assign addr_hit = (sel_port >= PWI_PORT_MIN) && (sel_port <= PWI_PORT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Per-port status view, wake and interrupt terms.
  for (genvar g = PWI_PORT_FIRST; g <= PWI_PORT_LAST; g++) begin : g_port
    assign is_phy[g]   = (g <= PWI_PHY_LAST);
    // The PHY source only exists on ports with an integrated PHY.
    assign flags[g]    = {port_evt.phy_irq[g] & is_phy[g], st.port[g].acl_st};
    assign wake_hit[g] = |(st.port[g].evt & st.port[g].ena);
    assign irq_hit[g]  = |(flags[g] & ~st.port[g].mask);
    assign ena_set[g]  = |st.port[g].ena;
  end

  // Both outputs are levels: wake follows the stored event flags, port_irq the stored ACL flag and the live PHY input.
  assign wake_output = |wake_hit;
  assign port_irq    = |irq_hit;

  // One wait cycle: the answer stands in the cycle after the request is seen.
  assign avs_waitrequest = (avs_read || avs_write) && (st.bus != PWI_BUS_DONE);
  assign avs_readdata    = st.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the bus handshake and every port register.
  always_comb begin
    logic [7:0] rd_value;
    logic       wr_now;
    logic       wr_p;
    logic       toggle;
    logic [2:0] evt_clr;
    logic [2:0] evt_set;
    rd_value = 8'h00;
    wr_now   = 1'b0;
    wr_p     = 1'b0;
    toggle   = 1'b0;
    evt_clr  = 3'h0;
    evt_set  = 3'h0;
    next_st  = st;
    // Writes take effect at the edge where waitrequest is seen low.
    wr_now = (st.bus == PWI_BUS_DONE) && avs_write && addr_hit;
    for (int p = PWI_PORT_FIRST; p <= PWI_PORT_LAST; p++) begin
      wr_p = wr_now && (sel_port == 4'(p));
      // Read mux; reads have no side effect on any flag.
      if (addr_hit && sel_port == 4'(p)) begin
        case (sel_reg)
          PWI_REG_TAG_HIGH: rd_value = st.port[p].tag_high;
          PWI_REG_TAG_LOW:  rd_value = st.port[p].tag_low;
          PWI_REG_EVT:      rd_value = {5'h00, st.port[p].evt};
          PWI_REG_ENA:      rd_value = {5'h00, st.port[p].ena};
          PWI_REG_IRQ:      rd_value = {6'h00, flags[p]};
          PWI_REG_MASK:     rd_value = {6'h00, st.port[p].mask};
          default:          rd_value = 8'h00;
        endcase
      end
      if (wr_p && sel_reg == PWI_REG_TAG_HIGH) begin
        next_st.port[p].tag_high = avs_writedata;
      end
      if (wr_p && sel_reg == PWI_REG_TAG_LOW) begin
        next_st.port[p].tag_low = avs_writedata;
      end
      if (wr_p && sel_reg == PWI_REG_ENA) begin
        next_st.port[p].ena = avs_writedata[2:0];
      end
      if (wr_p && sel_reg == PWI_REG_MASK) begin
        next_st.port[p].mask = avs_writedata[1:0];
      end
      // Write one to clear; a new event in the same cycle wins.
      evt_clr = (wr_p && sel_reg == PWI_REG_EVT) ? avs_writedata[2:0] : 3'h0;
      evt_set[PWI_BIT_MAGIC]  = port_evt.magic[p];
      evt_set[PWI_BIT_LINK]   = port_evt.link[p] & is_phy[p];
      evt_set[PWI_BIT_ENERGY] = port_evt.energy[p] & is_phy[p];
      next_st.port[p].evt = (st.port[p].evt & ~evt_clr) | evt_set;
      // The ACL flag clears only on a change of the ACL mask bit.
      toggle = wr_p && (sel_reg == PWI_REG_MASK) && (avs_writedata[PWI_BIT_ACL] != st.port[p].mask[PWI_BIT_ACL]);
      next_st.port[p].acl_st = port_evt.acl_irq[p] | (st.port[p].acl_st & ~toggle);
    end
    case (st.bus)
      PWI_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_st.bus = PWI_BUS_DONE;
        end
        if (avs_read) begin
          next_st.rdata = rd_value;
        end
      end
      PWI_BUS_DONE: begin
        next_st.bus = PWI_BUS_IDLE;
      end
      default: begin
        next_st.bus = PWI_BUS_IDLE;
      end
    endcase
    if (reset) begin
      for (int p = PWI_PORT_FIRST; p <= PWI_PORT_LAST; p++) begin
        next_st.port[p].tag_high = PWI_TAG_HIGH_RST;
        next_st.port[p].tag_low  = PWI_TAG_LOW_RST;
        next_st.port[p].evt      = PWI_EVT_RST;
        next_st.port[p].ena      = PWI_ENA_RST;
        next_st.port[p].acl_st   = 1'b0;
        next_st.port[p].mask     = PWI_MASK_RST;
      end
      next_st.bus   = PWI_BUS_IDLE;
      next_st.rdata = PWI_RDATA_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset is applied through the next-state logic.
  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the bus handshake and the register behaviour.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence seq_req_idle;
    (avs_read || avs_write) && (st.bus == PWI_BUS_IDLE);
  endsequence

  // A mask write on the MAC port that flips the ACL mask bit, at the edge where it lands.
  sequence seq_mask6_toggle;
    (st.bus == PWI_BUS_DONE) && avs_write && (avs_address == 16'h601f)
      && (avs_writedata[0] != st.port[6].mask[0]);
  endsequence

  // A write to the given word address at the edge where it takes effect.
  sequence seq_wr_taken(logic [15:0] a);
    (st.bus == PWI_BUS_DONE) && avs_write && (avs_address == a);
  endsequence

  // A read of the given word address as it is first seen by an idle bus.
  sequence seq_rd_seen(logic [15:0] a);
    avs_read && (st.bus == PWI_BUS_IDLE) && (avs_address == a);
  endsequence

  chk_bus_one_wait: assert property (seq_req_idle |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Answer did not come after exactly one wait cycle.");

  chk_unmapped_read: assert property (seq_req_idle and (avs_read && !addr_hit) |=> avs_readdata == 8'h00)
    else $error("Unmapped read did not return zero.");

  chk_tag_reset: assert property ($fell(reset) |-> st.port[1].tag_high == 8'h00 && st.port[6].tag_low == 8'h01)
    else $error("Default tag bytes have wrong reset values.");

  chk_magic_set: assert property (port_evt.magic[5] |=> st.port[5].evt[2] ##1 st.port[5].evt[2] || $past(avs_write))
    else $error("Magic packet event was not captured and held.");

  chk_mac_no_phy: assert property (st.port[6].evt[1:0] == 2'b00)
    else $error("Link or energy event set on the MAC port.");

  chk_energy_set: assert property (port_evt.energy[3] |=> st.port[3].evt[0])
    else $error("Energy event was not captured.");

  chk_wake_magic: assert property (port_evt.magic[5] && st.port[5].ena[2] |=> wake_output)
    else $error("Enabled magic packet did not raise wake.");

  chk_wake_link: assert property (port_evt.link[4] && st.port[4].ena[1] |=> wake_output)
    else $error("Enabled link up did not raise wake.");

  chk_wake_quiet: assert property (ena_set == 6'h00 |-> !wake_output)
    else $error("Wake raised with every enable clear.");

  chk_phy_mac_zero: assert property (seq_req_idle and (avs_read && avs_address == 16'h601b) |=> !avs_readdata[1])
    else $error("MAC port reported a PHY interrupt.");

  chk_acl_toggle: assert property (seq_mask6_toggle and !port_evt.acl_irq[6] |=> !st.port[6].acl_st)
    else $error("Mask toggle did not clear the ACL status.");

  chk_acl_sticky: assert property (st.port[6].acl_st && !(avs_write && avs_address == 16'h601f) |=> st.port[6].acl_st)
    else $error("ACL status cleared without a mask toggle.");

  chk_irq_gate: assert property (st.port[6].acl_st && !st.port[6].mask[0] |-> port_irq)
    else $error("Unmasked ACL status did not raise the interrupt.");

  chk_mask_reset: assert property ($fell(reset) |-> st.port[4].mask == 2'b00)
    else $error("Mask register did not reset to enabled.");

  ////////////////////////////////////////////////////////////////////////////
  // Further checks on the handshake itself.

  // With no request on the bus the slave never stalls.
  chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("Waitrequest high without a request.");

  // The answer cycle always hands the bus back to idle.
  chk_done_returns: assert property (st.bus == PWI_BUS_DONE |=> st.bus == PWI_BUS_IDLE)
    else $error("Bus stayed in the answer cycle.");

  // Read data only move when a new read is taken.
  chk_rdata_hold: assert property (!(avs_read && st.bus == PWI_BUS_IDLE) |=> $stable(avs_readdata))
    else $error("Read data changed without a new read.");

  // A write outside the mapped ports leaves every port register alone.
  chk_unmapped_write: assert property ((st.bus == PWI_BUS_DONE) && avs_write && !addr_hit && port_evt == '0
    |=> $stable(st.port))
    else $error("Unmapped write changed a port register.");

  ////////////////////////////////////////////////////////////////////////////
  // Register writes land with the data held at the answer edge.

  // Tag high byte of port 1 takes the written byte.
  chk_tag_high_wr: assert property (seq_wr_taken(16'h1000) |=> st.port[1].tag_high == $past(avs_writedata))
    else $error("Tag high byte write did not land.");

  // Tag low byte of port 1 takes the written byte.
  chk_tag_low_wr: assert property (seq_wr_taken(16'h1001) |=> st.port[1].tag_low == $past(avs_writedata))
    else $error("Tag low byte write did not land.");

  // Enable bits of port 3 take the low three written bits.
  chk_ena_wr: assert property (seq_wr_taken(16'h3017) |=> st.port[3].ena == $past(avs_writedata[2:0]))
    else $error("Enable write did not land.");

  // Mask bits of port 4 take the low two written bits.
  chk_mask_wr: assert property (seq_wr_taken(16'h401f) |=> st.port[4].mask == $past(avs_writedata[1:0]))
    else $error("Mask write did not land.");

  ////////////////////////////////////////////////////////////////////////////
  // Event flags: set, sticky, write one to clear.

  // Link up on a PHY port is captured.
  chk_link_set: assert property (port_evt.link[4] |=> st.port[4].evt[1])
    else $error("Link up event was not captured.");

  // A one written to the energy flag clears it when no new event arrives.
  chk_evt_clear: assert property (seq_wr_taken(16'h3013) and (avs_writedata[0] && !port_evt.energy[3])
    |=> !st.port[3].evt[0])
    else $error("Energy flag did not clear on a written one.");

  // The energy flag holds until a write to the event register.
  chk_evt_sticky: assert property (st.port[3].evt[0] && !(avs_write && avs_address == 16'h3013)
    |=> st.port[3].evt[0])
    else $error("Energy flag dropped without a clear.");

  // Enabled energy detection raises wake.
  chk_wake_energy: assert property (port_evt.energy[3] && st.port[3].ena[0] |=> wake_output)
    else $error("Enabled energy detection did not raise wake.");

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and its mask.

  // An access-control event sets the MAC port status.
  chk_acl_set: assert property (port_evt.acl_irq[6] |=> st.port[6].acl_st)
    else $error("ACL event did not set the status.");

  // Writing the status register never changes it.
  chk_irq_ro: assert property (seq_wr_taken(16'h601b) and !port_evt.acl_irq[6] |=> $stable(st.port[6].acl_st))
    else $error("Status write changed the ACL status.");

  // An unmasked PHY interrupt on a PHY port raises the request.
  chk_phy_unmasked: assert property (port_evt.phy_irq[4] && !st.port[4].mask[1] |-> port_irq)
    else $error("Unmasked PHY interrupt did not raise the request.");

  // Reserved status bits read back as zero.
  chk_irq_reserved: assert property (seq_rd_seen(16'h401b) |=> avs_readdata[7:2] == 6'h00)
    else $error("Reserved status bits read as nonzero.");

  ////////////////////////////////////////////////////////////////////////////
  // Remaining values after reset.

  // The opposite tag bytes of the outer ports reset as well.
  chk_tag_reset_b: assert property ($fell(reset) |-> st.port[1].tag_low == 8'h01 && st.port[6].tag_high == 8'h00)
    else $error("Default tag bytes have wrong reset values.");

  // Events and enables start clear, so wake starts low.
  chk_evt_reset: assert property ($fell(reset) |-> st.port[5].evt == 3'h0 && st.port[5].ena == 3'h0)
    else $error("Event or enable bits not clear after reset.");

  // Wake is low straight after reset.
  chk_wake_reset: assert property ($fell(reset) |-> !wake_output)
    else $error("Wake high after reset.");

endmodule // pwi_port_regs
`default_nettype wire

//--- bench/pwi_port_regs_tb_top.sv
// Self-checking testbench for the per-port wake and interrupt register bank.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module pwi_port_regs_tb_top;
  import pwi_pkg::*;

  logic        ref_clk;
  logic        reset;
  logic [15:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [7:0]  avs_writedata;
  logic [7:0]  avs_readdata;
  logic        avs_waitrequest;
  pwi_evt_s    port_evt;
  logic        wake_output;
  logic        port_irq;
  logic [7:0]  exp_q[$];
  logic [7:0]  mon_exp;
  logic [7:0]  v;
  int          fail_count;
  int          comparisons;
  int          p;
  int          b;

  ////////////////////////////////////////////////////////////////////////////
  // The clock toggles every half period of 5 ns.
  always #5 ref_clk = ~ref_clk;

  pwi_port_regs i_dut (
    .ref_clk         (ref_clk),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .port_evt        (port_evt),
    .wake_output     (wake_output),
    .port_irq        (port_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One bus cycle; the request is held to the rising edge after waitrequest is seen low at a falling edge.
  task automatic bus(input logic wr, input logic [3:0] prt, input logic [11:0] rg, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address   <= {prt, rg};
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= d;
    do @(negedge ref_clk); while (avs_waitrequest !== 1'b0);
    @(posedge ref_clk);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // A read notes its expected data for the watching process.
  task automatic rd(input logic [3:0] prt, input logic [11:0] rg, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, prt, rg, 8'h00);
  endtask

  // Compares both level outputs once they have settled.
  task automatic lvl(input logic ew, input logic ei);
    @(negedge ref_clk);
    `CHK("wake_output", ew, wake_output)
    `CHK("port_irq", ei, port_irq)
  endtask

  // A one-cycle event pulse: 2 magic, 1 link, 0 energy, 3 access-control.
  task automatic pulse(input int k, input int prt);
    @(posedge ref_clk);
    case (k)
      2: port_evt.magic[prt] <= 1'b1;
      1: port_evt.link[prt] <= 1'b1;
      0: port_evt.energy[prt] <= 1'b1;
      default: port_evt.acl_irq[prt] <= 1'b1;
    endcase
    @(posedge ref_clk);
    port_evt.magic   <= '0;
    port_evt.link    <= '0;
    port_evt.energy  <= '0;
    port_evt.acl_irq <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Takes the oldest note whenever read data are answered and compares.
  always @(negedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      mon_exp = exp_q.pop_front();
      `CHK("readdata", mon_exp, avs_readdata)
    end
  end

  // Cuts a hang short well beyond the expected length of the run.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end

  // Main sequence of scenarios.
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    port_evt = '0;
    void'($urandom(32'h0000_5c12));
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    for (p = 1; p <= 6; p++) begin
      rd(4'(p), PWI_REG_TAG_HIGH, 8'h00);
      rd(4'(p), PWI_REG_TAG_LOW, 8'h01);
      rd(4'(p), PWI_REG_EVT, 8'h00);
      rd(4'(p), PWI_REG_MASK, 8'h00);
    end
    lvl(1'b0, 1'b0);
    for (p = 1; p <= 6; p++) begin
      v = 8'($urandom);
      bus(1'b1, 4'(p), PWI_REG_TAG_HIGH, v);
      bus(1'b1, 4'(p), PWI_REG_TAG_LOW, ~v);
      rd(4'(p), PWI_REG_TAG_HIGH, v);
      rd(4'(p), PWI_REG_TAG_LOW, ~v);
    end
    // Port numbers 0, 7 and 14 and an unlisted index decode to nothing.
    for (p = 0; p < 16; p += 7) begin
      bus(1'b1, 4'(p), PWI_REG_TAG_HIGH, 8'h5a);
      rd(4'(p), PWI_REG_TAG_HIGH, 8'h00);
    end
    rd(4'h1, 12'h002, 8'h00);
    for (b = 0; b <= 2; b++) begin
      p = b + 3;
      pulse(b, p);
      rd(4'(p), PWI_REG_EVT, 8'h01 << b);
      lvl(1'b0, 1'b0);
      bus(1'b1, 4'(p), PWI_REG_ENA, 8'h01 << b);
      lvl(1'b1, 1'b0);
      bus(1'b1, 4'(p), PWI_REG_ENA, 8'h07);
      pulse(b, p);
      lvl(1'b1, 1'b0);
      bus(1'b1, 4'(p), PWI_REG_EVT, 8'h01 << b);
      rd(4'(p), PWI_REG_EVT, 8'h00);
      lvl(1'b0, 1'b0);
      bus(1'b1, 4'(p), PWI_REG_ENA, 8'h00);
    end
    pulse(1, 6);
    pulse(0, 6);
    rd(4'h6, PWI_REG_EVT, 8'h00);
    @(posedge ref_clk);
    port_evt.phy_irq <= 6'b10_1000;
    rd(4'h4, PWI_REG_IRQ, 8'h02);
    rd(4'h6, PWI_REG_IRQ, 8'h00);
    lvl(1'b0, 1'b1);
    bus(1'b1, 4'h4, PWI_REG_MASK, 8'h02);
    lvl(1'b0, 1'b0);
    @(posedge ref_clk);
    port_evt.phy_irq <= '0;
    pulse(3, 6);
    rd(4'h6, PWI_REG_IRQ, 8'h01);
    rd(4'h6, PWI_REG_IRQ, 8'h01);
    lvl(1'b0, 1'b1);
    bus(1'b1, 4'h6, PWI_REG_IRQ, 8'hff);
    rd(4'h6, PWI_REG_IRQ, 8'h01);
    bus(1'b1, 4'h6, PWI_REG_MASK, 8'h01);
    rd(4'h6, PWI_REG_IRQ, 8'h00);
    pulse(3, 6);
    rd(4'h6, PWI_REG_IRQ, 8'h01);
    lvl(1'b0, 1'b0);
    summarize();
  end

endmodule // pwi_port_regs_tb_top
`default_nettype wire
